// [audio_clk_pkg.sv]
// constants, types and decode functions of the serial audio port clocking block
package audio_clk_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STAT_OFS    = 8'h04;
  localparam logic [7:0] RATIO_OFS   = 8'h08;
  localparam int         CTRL_SW     = 0;
  localparam int         CTRL_MASTER = 1;
  localparam int         CTRL_AUTO   = 2;
  localparam int         CTRL_SPEED  = 3;
  localparam int         CTRL_HALVE  = 5;
  localparam int         CTRL_HIZ    = 6;
  localparam int         CTRL_LJ     = 7;
  localparam int         CTRL_WLEN   = 8;
  localparam int         CTRL_W      = 10;
  localparam logic [9:0] CTRL_RST    = 10'h314;
  localparam int         STAT_OVR    = 0;
  localparam int         STAT_ROLE   = 1;
  localparam int         STAT_MODE   = 2;
  localparam int         STAT_LOCK   = 4;
  localparam int         STAT_RERR   = 5;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int         RATIO_W    = 13;
  localparam int         SAMPLE_W   = 24;
  localparam int         PLAY_W     = 2 * SAMPLE_W;
  localparam int         BUF_DEPTH  = 2;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [5:0] IDX_MAX    = 6'h3f;

  // internal master clock ticks per frame, after halving
  localparam logic [12:0] R_Q_A = 13'h0400;
  localparam logic [12:0] R_Q_B = 13'h0600;
  localparam logic [12:0] R_H_A = 13'h0200;
  localparam logic [12:0] R_H_B = 13'h0300;
  localparam logic [12:0] R_S_A = 13'h0100;
  localparam logic [12:0] R_S_B = 13'h0180;
  localparam logic [12:0] R_D_A = 13'h0080;
  localparam logic [12:0] R_D_B = 13'h00c0;
  // external ratio windows with detection off
  localparam logic [12:0] M_Q_MAX = 13'h0c00;
  localparam logic [12:0] M_H_MAX = 13'h0600;
  localparam logic [12:0] M_S_MAX = 13'h0300;

  typedef enum logic [1:0] {
    quarter_rate_mode, half_rate_mode, single_rate_mode, double_rate_mode
  } rate_mode_t;

  // master bit clock half period in internal ticks; 64 bit clocks per frame
  function automatic logic [3:0] half_period(input rate_mode_t m);
    case (m)
      quarter_rate_mode: half_period = 4'h8;
      half_rate_mode:    half_period = 4'h4;
      single_rate_mode:  half_period = 4'h2;
      default:           half_period = 4'h1;
    endcase
  endfunction : half_period

  function automatic logic [4:0] word_len(input logic [1:0] f);
    case (f)
      2'h0:    word_len = 5'h10;
      2'h1:    word_len = 5'h12;
      2'h2:    word_len = 5'h14;
      default: word_len = 5'h18;
    endcase
  endfunction : word_len

  // {accepted, mode} from a measured internal ratio
  function automatic logic [2:0] detect_mode(input logic [RATIO_W-1:0] r);
    case (r)
      R_Q_A, R_Q_B: detect_mode = {1'b1, quarter_rate_mode};
      R_H_A, R_H_B: detect_mode = {1'b1, half_rate_mode};
      R_S_A, R_S_B: detect_mode = {1'b1, single_rate_mode};
      R_D_A, R_D_B: detect_mode = {1'b1, double_rate_mode};
      default:      detect_mode = 3'h0;
    endcase
  endfunction : detect_mode

  function automatic logic manual_ok(input rate_mode_t m, input logic [RATIO_W-1:0] x);
    case (m)
      quarter_rate_mode: manual_ok = x >= R_H_A && x <= M_Q_MAX;
      half_rate_mode:    manual_ok = x >= R_S_A && x <= M_H_MAX;
      single_rate_mode:  manual_ok = x >= R_D_A && x <= M_S_MAX;
      default:           manual_ok = x >= R_D_A && x <= R_S_B;
    endcase
  endfunction : manual_ok

endpackage : audio_clk_pkg

// [stream_if.sv]
// valid/ready carrier for stereo sample pairs
`timescale 1ns/1ps
`default_nettype none
interface stream_if;
  import audio_clk_pkg::*;
  logic              valid;
  logic              ready;
  logic [PLAY_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if
`default_nettype wire

// [ratio_meter.sv]
// counts internal master clock ticks over one frame clock period
`timescale 1ns/1ps
`default_nettype none
module ratio_meter (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst_n,
  // events
  input  wire logic                             enable,
  input  wire logic                             tick,
  input  wire logic                             frame_rise,
  // result
  output logic [audio_clk_pkg::RATIO_W-1:0]     ratio_q,
  output logic                                  valid_q
);
  import audio_clk_pkg::*;

  logic [RATIO_W-1:0] cnt_q;
  logic               started_q;

  // first frame edge only opens the window; a count that saturates never matches a ratio
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= '0;
      started_q <= 1'b0;
      ratio_q   <= '0;
      valid_q   <= 1'b0;
    end else if (!enable) begin
      cnt_q     <= '0;
      started_q <= 1'b0;
      valid_q   <= 1'b0;
    end else if (frame_rise) begin
      if (started_q) begin
        ratio_q <= cnt_q;
        valid_q <= 1'b1;
      end
      started_q <= 1'b1;
      cnt_q     <= RATIO_W'(tick);
    end else if (tick && cnt_q != '1) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule : ratio_meter
`default_nettype wire

// [play_buffer.sv]
// two-entry buffer for received sample pairs
`timescale 1ns/1ps
`default_nettype none
module play_buffer (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // streams
  stream_if.snk     in_s,
  stream_if.src     out_s
);
  import audio_clk_pkg::*;

  logic [PLAY_W-1:0] mem_q [BUF_DEPTH];
  logic              wr_q;
  logic              rd_q;
  logic [1:0]        cnt_q;
  logic              push;
  logic              pop;

  assign in_s.ready  = cnt_q != 2'(BUF_DEPTH);
  assign out_s.valid = cnt_q != 2'h0;
  assign out_s.data  = mem_q[rd_q];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_s.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
endmodule : play_buffer
`default_nettype wire

// [audio_port_clocking.sv]
// serial audio port clocking: role strap, clock halving, rate detection, clock generation, sample shifting
// Contract
// - runs as slave on outside clocks or master making them from master clock.
// - frame clock equals sample rate; one sample per channel per frame.
// - hardware mode latches strap pin once after power-up: low slave, high master.
// - halving control high divides master clock by two before all logic, else passes.
// - slave takes frame and bit clocks in; auto-detect picks speed from measured ratio.
// - detection off: speed field selects mode within the wider ratio windows.
// - master derives frame and bit clocks from internal clock after halving.
// - hardware mode master runs single speed only.
// - software mode master runs the speed selected by the two-bit field.
// - tristate control releases all port clock and data drivers.
// - capture data driven, playback data taken, on bit clock rising edge.
// - ratio counted over one frame period before normal operation starts; master role counts nothing and starts once the strap is taken.
// - I2S or left-justified formats, word lengths 16 to 24 bits.
`timescale 1ns/1ps
`default_nettype none
module audio_port_clocking (
  // apb slave
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [7:0]                           paddr,
  input  wire logic [31:0]                          pwdata,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  // clock pins
  input  wire logic                                 mclk_pin,
  input  wire logic                                 master_clk_halve,
  input  wire logic                                 bit_clk_i,
  output logic                                      bit_clk_o,
  output logic                                      bit_clk_oe_n,
  input  wire logic                                 frame_clk_i,
  output logic                                      frame_clk_o,
  output logic                                      frame_clk_oe_n,
  // data pins
  input  wire logic                                 play_in,
  input  wire logic                                 capture_out_role_strap_i,
  output logic                                      capture_out_role_strap_o,
  output logic                                      capture_out_role_strap_oe_n,
  // capture samples
  input  wire logic [audio_clk_pkg::SAMPLE_W-1:0]   cap_left,
  input  wire logic [audio_clk_pkg::SAMPLE_W-1:0]   cap_right,
  // playback sample pairs, left in upper half
  output logic                                      play_valid,
  input  wire logic                                 play_ready,
  output logic      [audio_clk_pkg::PLAY_W-1:0]     play_data
);
  import audio_clk_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int NS = 6;
  localparam int P_MCLK = 0;
  localparam int P_HALVE = 1;
  localparam int P_BCLK = 2;
  localparam int P_FCLK = 3;
  localparam int P_DIN = 4;
  localparam int P_STRAP = 5;

  logic [NS-1:0] pins;
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  logic [NS-1:0] sync3_q;

  assign pins = {capture_out_role_strap_i, play_in, frame_clk_i, bit_clk_i, master_clk_halve, mclk_pin};

  genvar g;
  generate
    for (g = 0; g < NS; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= pins[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // registers and apb slave
  // ****************************************
  logic [CTRL_W-1:0]  ctrl_q;
  logic [31:0]        prdata_q;
  logic [31:0]        rd_word;
  logic [31:0]        stat_word;
  logic               ovr_q;
  logic               ovr_set;
  logic               ovr_clr;
  logic               wr_acc;
  logic               role_master;
  logic               lock_q;
  logic               ratio_err;
  rate_mode_t         mode;
  logic [RATIO_W-1:0] ratio_q;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = a == CTRL_OFS || a == STAT_OFS || a == RATIO_OFS;
  endfunction : addr_hit

  assign wr_acc  = psel & penable & pwrite & addr_hit(paddr);
  assign ovr_clr = wr_acc && paddr == STAT_OFS && pwdata[STAT_OVR];
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit(paddr);
  assign prdata  = prdata_q;

  always_comb begin
    stat_word                            = '0;
    stat_word[STAT_OVR]                  = ovr_q;
    stat_word[STAT_ROLE]                 = role_master;
    stat_word[STAT_MODE +: 2]            = mode;
    stat_word[STAT_LOCK]                 = lock_q;
    stat_word[STAT_RERR]                 = ratio_err;
    case (paddr)
      CTRL_OFS:  rd_word = {{(32-CTRL_W){1'b0}}, ctrl_q};
      STAT_OFS:  rd_word = stat_word;
      RATIO_OFS: rd_word = {{(32-RATIO_W){1'b0}}, ratio_q};
      default:   rd_word = '0;
    endcase
  end

  // read data is captured in the setup phase so the access phase answers from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_acc && paddr == CTRL_OFS) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end

  // a new overrun in the clearing cycle stays set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_q <= 1'b0;
    end else begin
      ovr_q <= ovr_set | (ovr_q & ~ovr_clr);
    end
  end

  // ****************************************
  // role strap, halving and mode choice
  // ****************************************
  logic               sw_mode;
  logic               halve;
  logic               auto_en;
  logic               hiz;
  logic [1:0]         strap_cnt_q;
  logic               strap_done_q;
  logic               strap_role_q;
  logic               half_ph_q;
  logic               mclk_rise;
  logic               tick;
  logic               meter_valid;
  logic [2:0]         det;
  logic [RATIO_W-1:0] ext_ratio;
  logic               ratio_ok;

  assign sw_mode     = ctrl_q[CTRL_SW];
  assign halve       = sw_mode ? ctrl_q[CTRL_HALVE] : sync2_q[P_HALVE];
  assign auto_en     = ~sw_mode | ctrl_q[CTRL_AUTO];
  assign hiz         = ctrl_q[CTRL_HIZ];
  assign role_master = sw_mode ? ctrl_q[CTRL_MASTER] : strap_role_q;

  // strap is taken once the synchroniser has filled, and never again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_cnt_q  <= 2'h0;
      strap_done_q <= 1'b0;
      strap_role_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == STRAP_WAIT) begin
        strap_done_q <= 1'b1;
        strap_role_q <= sync2_q[P_STRAP];
      end
    end
  end

  // master clock is sampled, so it must stay well below half the bus clock
  assign mclk_rise = sync2_q[P_MCLK] & ~sync3_q[P_MCLK];
  assign tick      = mclk_rise & (~halve | half_ph_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ph_q <= 1'b0;
    end else if (!halve) begin
      half_ph_q <= 1'b0;
    end else if (mclk_rise) begin
      half_ph_q <= ~half_ph_q;
    end
  end

  ratio_meter u_meter (
    .clk        (pclk),
    .rst_n      (presetn),
    .enable     (~role_master),
    .tick       (tick),
    .frame_rise (sync2_q[P_FCLK] & ~sync3_q[P_FCLK]),
    .ratio_q    (ratio_q),
    .valid_q    (meter_valid)
  );

  assign det       = detect_mode(ratio_q);
  assign ext_ratio = halve ? {ratio_q[RATIO_W-2:0], 1'b0} : ratio_q;

  always_comb begin
    if (role_master) begin
      mode = sw_mode ? rate_mode_t'(ctrl_q[CTRL_SPEED +: 2]) : single_rate_mode;
    end else if (auto_en) begin
      mode = rate_mode_t'(det[1:0]);
    end else begin
      mode = rate_mode_t'(ctrl_q[CTRL_SPEED +: 2]);
    end
  end

  assign ratio_ok  = auto_en ? det[2] : manual_ok(mode, ext_ratio);
  assign ratio_err = ~role_master & meter_valid & ~ratio_ok;

  // in slave role shifting starts only after a full frame has been measured and accepted; in master role once the strap is taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 1'b0;
    end else begin
      lock_q <= role_master ? strap_done_q : meter_valid & ratio_ok;
    end
  end

  // ****************************************
  // master clock generation
  // ****************************************
  logic       m_run;
  logic [3:0] hp_cnt_q;
  logic       bclk_q;
  logic [5:0] bit_cnt_q;
  logic       fclk_q;
  logic       hp_end;
  logic       m_rise;

  assign m_run  = role_master & strap_done_q;
  assign hp_end = tick && hp_cnt_q == 4'(half_period(mode) - 4'h1);
  assign m_rise = m_run & hp_end & ~bclk_q;

  // frame changes on a falling bit clock so the far end samples it stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_cnt_q  <= 4'h0;
      bclk_q    <= 1'b0;
      bit_cnt_q <= 6'h0;
      fclk_q    <= 1'b0;
    end else if (!m_run) begin
      hp_cnt_q  <= 4'h0;
      bclk_q    <= 1'b0;
      bit_cnt_q <= 6'h0;
      fclk_q    <= 1'b0;
    end else if (hp_end) begin
      hp_cnt_q <= 4'h0;
      bclk_q   <= ~bclk_q;
      if (bclk_q) begin
        bit_cnt_q <= bit_cnt_q + 6'h1;
        fclk_q    <= bit_cnt_q[5] ^ (&bit_cnt_q[4:0]);
      end
    end else if (tick) begin
      hp_cnt_q <= hp_cnt_q + 4'h1;
    end
  end

  // ****************************************
  // sample shifting
  // ****************************************
  logic                bit_rise;
  logic                frame_lvl;
  logic                last_frame_q;
  logic                new_half;
  logic [5:0]          idx_q;
  logic [5:0]          idx_d;
  logic                lj;
  logic                pos_valid;
  logic [5:0]          posn;
  logic [4:0]          wlen;
  logic                emit;
  logic                last_bit;
  logic                chan_right;
  logic [SAMPLE_W-1:0] rx_sh_q;
  logic [SAMPLE_W-1:0] rx_next;
  logic [SAMPLE_W-1:0] word_al;
  logic [SAMPLE_W-1:0] left_q;
  logic [SAMPLE_W-1:0] tx_sh_q;
  logic [SAMPLE_W-1:0] tx_now;
  logic [SAMPLE_W-1:0] cap_r_q;
  logic                cap_bit_q;
  logic                push_valid_q;
  logic [PLAY_W-1:0]   push_data_q;

  stream_if push_if ();
  stream_if pop_if ();

  assign bit_rise   = lock_q & (role_master ? m_rise : sync2_q[P_BCLK] & ~sync3_q[P_BCLK]);
  assign frame_lvl  = role_master ? fclk_q : sync2_q[P_FCLK];
  assign new_half   = frame_lvl != last_frame_q;
  assign idx_d      = new_half ? 6'h0 : (idx_q == IDX_MAX ? idx_q : idx_q + 6'h1);
  assign lj         = ctrl_q[CTRL_LJ];
  assign pos_valid  = lj | (idx_d != 6'h0);
  assign posn       = lj ? idx_d : idx_d - 6'h1;
  assign wlen       = word_len(ctrl_q[CTRL_WLEN +: 2]);
  assign emit       = pos_valid && posn < {1'b0, wlen};
  assign last_bit   = emit && posn == {1'b0, wlen} - 6'h1;
  assign chan_right = lj ? ~frame_lvl : frame_lvl;
  assign rx_next    = {rx_sh_q[SAMPLE_W-2:0], sync2_q[P_DIN]};
  assign word_al    = rx_next << (5'(SAMPLE_W) - wlen);
  assign tx_now     = new_half ? (chan_right ? cap_r_q : cap_left) : tx_sh_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_frame_q <= 1'b0;
      idx_q        <= 6'h0;
      rx_sh_q      <= '0;
      left_q       <= '0;
      tx_sh_q      <= '0;
      cap_r_q      <= '0;
      cap_bit_q    <= 1'b0;
    end else if (bit_rise) begin
      last_frame_q <= frame_lvl;
      idx_q        <= idx_d;
      if (new_half && !chan_right) cap_r_q <= cap_right;
      if (emit) begin
        rx_sh_q   <= rx_next;
        cap_bit_q <= tx_now[SAMPLE_W-1];
        tx_sh_q   <= tx_now << 1;
      end else begin
        cap_bit_q <= 1'b0;
        tx_sh_q   <= tx_now;
      end
      if (last_bit && !chan_right) left_q <= word_al;
    end
  end

  // the serial side cannot wait, so a pair refused by a full buffer is flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      push_valid_q <= 1'b0;
      push_data_q  <= '0;
    end else begin
      push_valid_q <= bit_rise & last_bit & chan_right;
      if (bit_rise && last_bit && chan_right) push_data_q <= {left_q, word_al};
    end
  end

  assign ovr_set       = push_valid_q & ~push_if.ready;
  assign push_if.valid = push_valid_q;
  assign push_if.data  = push_data_q;
  assign pop_if.ready  = play_ready;
  assign play_valid    = pop_if.valid;
  assign play_data     = pop_if.data;

  play_buffer u_buf (
    .clk   (pclk),
    .rst_n (presetn),
    .in_s  (push_if.snk),
    .out_s (pop_if.src)
  );

  // ****************************************
  // pin drivers
  // ****************************************
  logic clk_oe_n_q;
  logic dat_oe_n_q;

  // the strap pin stays released until its level has been taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_oe_n_q <= 1'b1;
      dat_oe_n_q <= 1'b1;
    end else begin
      clk_oe_n_q <= ~(m_run & ~hiz);
      dat_oe_n_q <= ~(strap_done_q & lock_q & ~hiz);
    end
  end

  assign bit_clk_o                   = bclk_q;
  assign frame_clk_o                 = fclk_q;
  assign bit_clk_oe_n                = clk_oe_n_q;
  assign frame_clk_oe_n              = clk_oe_n_q;
  assign capture_out_role_strap_o    = cap_bit_q;
  assign capture_out_role_strap_oe_n = dat_oe_n_q;

endmodule : audio_port_clocking
`default_nettype wire

// [audio_port_clocking_asserts.sv]
// concurrent checks on the audio port clocking block pins
`timescale 1ns/1ps
`default_nettype none
module audio_port_clocking_asserts (
  // apb
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  // port pins and playback
  input wire logic        bit_clk_o, bit_clk_oe_n, frame_clk_o, frame_clk_oe_n, play_valid, play_ready,
  input wire logic [audio_clk_pkg::PLAY_W-1:0] play_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc; psel && penable; endsequence
  sequence s_bad; s_acc ##0 (paddr > 8'h08 || paddr[1:0] != 2'h0); endsequence
  a_zero_wait: assert property (s_acc |-> pready)
    else $error("no ready in access");
  a_unmapped_err: assert property (s_bad ##0 !pwrite |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (s_acc ##0 !(paddr > 8'h08 || paddr[1:0] != 2'h0) |-> !pslverr)
    else $error("mapped access refused");
  a_err_window: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  a_read_stands: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("read data moved");
  a_oe_pair: assert property (bit_clk_oe_n == frame_clk_oe_n)
    else $error("clock drivers split");
  a_frame_edge: assert property (!frame_clk_oe_n && $changed(frame_clk_o) |-> !bit_clk_o)
    else $error("frame moved off bit fall");
  a_bit_runs: assert property (!bit_clk_oe_n |-> ##[1:80] ($changed(bit_clk_o) || bit_clk_oe_n))
    else $error("bit clock stalled");
  a_buf_hold: assert property (play_valid && !play_ready |=> play_valid && $stable(play_data))
    else $error("stalled pair lost");
endmodule : audio_port_clocking_asserts
`default_nettype wire

// [audio_host_model.sv]
// far-side audio controller: master clock, slave frame and bit clocks, playback data
`timescale 1ns/1ps
`default_nettype none
module audio_host_model (
  // control
  input  wire logic        en,
  input  wire logic [12:0] ratio,
  // pins
  output logic             mclk, bclk, fclk, sdata
);
  int n;
  initial begin
    {mclk, bclk, fclk, sdata} = 4'h0;
    n = 0;
  end
  // 25 mhz, edges fall on bus clock falling edges
  always #20 mclk = ~mclk;
  // bit and frame clocks stand still while released so the block sees no stray edges
  always @(posedge mclk) begin
    if (en) begin
      n <= (n + 1) % ratio;
      bclk <= (n % (ratio / 64)) >= ratio / 128;
      fclk <= n >= ratio / 2;
    end
  end
  always @(negedge bclk) sdata <= 1'($urandom);
endmodule : audio_host_model
`default_nettype wire

// [tb_top.sv]
// testbench: apb scoreboard, slave detection, master rates, tristate, buffer stall
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import audio_clk_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, halve, play_ready, play_valid;
  logic        host_en, bco, bcoe, fco, fcoe, cso, csoe, hm, hb, hf, hs;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [47:0] play_data;
  logic [23:0] cl, cr;
  logic [12:0] ratio;
  logic [32:0] eq[$];
  logic [31:0] mq[$];
  int          mismatches, checks_done, cyc;
  time         t0;
  // released pins: pull-down on the strap, far side on the clocks
  wire logic   bci = bcoe ? hb : bco;
  wire logic   fci = fcoe ? hf : fco;
  wire logic   csi = csoe ? 1'b0 : cso;
  audio_port_clocking dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mclk_pin(hm),
    .master_clk_halve(halve), .bit_clk_i(bci), .bit_clk_o(bco), .bit_clk_oe_n(bcoe),
    .frame_clk_i(fci), .frame_clk_o(fco), .frame_clk_oe_n(fcoe), .play_in(hs),
    .capture_out_role_strap_i(csi), .capture_out_role_strap_o(cso), .capture_out_role_strap_oe_n(csoe),
    .cap_left(cl), .cap_right(cr), .play_valid(play_valid), .play_ready(play_ready), .play_data(play_data));
  audio_host_model host (.en(host_en), .ratio(ratio), .mclk(hm), .bclk(hb), .fclk(hf), .sdata(hs));
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  task automatic chk(input logic [47:0] s, input logic [47:0] e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic print_verdict;
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // reads note {error, masked data} at setup; the monitor below compares
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                     input logic [31:0] m);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    if (!w) begin
      eq.push_back(e);
      mq.push_back(m);
    end
    @(posedge pclk); penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic per(input int m);
    @(posedge bco); @(posedge bco); t0 = $time;
    @(posedge bco); chk(48'(($time - t0) / 10), 48'(64 >> m));
    @(posedge fco); t0 = $time;
    @(posedge fco); chk(48'(($time - t0) / 10), 48'(4096 >> m));
  endtask : per
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      print_verdict();
    end
    if (psel && penable && pready && !pwrite && eq.size() > 0) begin
      chk({15'h0, pslverr, prdata & mq[0]}, {15'h0, eq[0]});
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, halve, cl, cr} = '0;
    play_ready = 1'b1; host_en = 1'b1; ratio = 13'h0100; mismatches = 0; checks_done = 0; cyc = 0;
    void'($urandom(32'hacb265f5));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, CTRL_OFS, 32'h0, {23'h0, CTRL_RST}, 32'h3ff);
    apb(1'b0, 8'h10, 32'h0, 33'h100000000, 32'hffffffff);
    cl <= 24'($urandom); cr <= 24'($urandom);
    repeat (4200) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0, 33'h18, 32'h1e);
    apb(1'b0, RATIO_OFS, 32'h0, 33'h100, 32'h1fff);
    halve <= 1'b1; ratio <= 13'h0200;
    repeat (8400) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0, 33'h18, 32'h1e);
    apb(1'b0, RATIO_OFS, 32'h0, 33'h100, 32'h1fff);
    // stall the sink long enough for a third pair to be dropped
    play_ready <= 1'b0;
    repeat (8000) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0, 33'h19, 32'h1f);
    play_ready <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(1'b1, STAT_OFS, 32'h1, 33'h0, 32'h0);
    apb(1'b0, STAT_OFS, 32'h0, 33'h18, 32'h1f);
    // manual speed choice in slave role: quarter accepts the doubled ratio, double refuses it
    apb(1'b1, CTRL_OFS, 32'h321, 33'h0, 32'h0);
    apb(1'b0, STAT_OFS, 32'h0, 33'h10, 32'h3e);
    apb(1'b1, CTRL_OFS, 32'h339, 33'h0, 32'h0);
    apb(1'b0, STAT_OFS, 32'h0, 33'h2c, 32'h3e);
    host_en <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, CTRL_OFS, 32'h303 | 32'(m << 3), 33'h0, 32'h0);
      @(negedge pclk);
      chk({46'h0, bcoe, fcoe}, 48'h0);
      per(m);
      apb(1'b0, STAT_OFS, 32'h0, 33'(m * 4 + 2), 32'h0e);
    end
    apb(1'b1, CTRL_OFS, 32'h343, 33'h0, 32'h0);
    repeat (4) @(posedge pclk);
    chk({45'h0, bcoe, fcoe, csoe}, 48'h7);
    print_verdict();
  end
endmodule : tb_top
bind audio_port_clocking audio_port_clocking_asserts chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .paddr(paddr), .prdata(prdata), .bit_clk_o(bit_clk_o), .bit_clk_oe_n(bit_clk_oe_n),
  .frame_clk_o(frame_clk_o), .frame_clk_oe_n(frame_clk_oe_n), .play_valid(play_valid),
  .play_ready(play_ready), .play_data(play_data));
`default_nettype wire
